/* src/mmd_pkg.sv */
`default_nettype none
package mmd_pkg;
	// ****************************************************************
	// Address map, word addresses on the 22-bit core bus.
	// ****************************************************************
	localparam logic [21:0] M01_LO = 22'h000000;
	localparam logic [21:0] M01_HI = 22'h0007FF;
	localparam logic [21:0] PF0_LO = 22'h000800;
	localparam logic [21:0] PF0_HI = 22'h000FFF;
	localparam logic [21:0] Z0_LO = 22'h002000;
	localparam logic [21:0] Z0_HI = 22'h003FFF;
	localparam logic [21:0] Z1_LO = 22'h004000;
	localparam logic [21:0] Z1_HI = 22'h005FFF;
	localparam logic [21:0] PF1_LO = 22'h006000;
	localparam logic [21:0] PF1_HI = 22'h006FFF;
	localparam logic [21:0] CAN_CTL_HI = 22'h0060FF;
	localparam logic [21:0] PF2_LO = 22'h007000;
	localparam logic [21:0] PF2_HI = 22'h007FFF;
	localparam logic [21:0] L01_LO = 22'h008000;
	localparam logic [21:0] L01_HI = 22'h009FFF;
	localparam logic [21:0] Z2_LO = 22'h080000;
	localparam logic [21:0] Z2_HI = 22'h0FFFFF;
	localparam logic [21:0] Z6_LO = 22'h100000;
	localparam logic [21:0] Z6_HI = 22'h17FFFF;
	localparam logic [21:0] OTP_LO = 22'h3D7800;
	localparam logic [21:0] OTP_HI = 22'h3D7BFF;
	localparam logic [21:0] FLASH_LO = 22'h3D8000;
	localparam logic [21:0] FLASH_HI = 22'h3F7FFF;
	localparam logic [21:0] ENTRY_LO = 22'h3F7FF6;
	localparam logic [21:0] ENTRY_HI = 22'h3F7FF7;
	localparam logic [21:0] PWD_LO = 22'h3F7FF8;
	localparam logic [21:0] PWD_HI = 22'h3F7FFF;
	localparam logic [21:0] H0_LO = 22'h3F8000;
	localparam logic [21:0] H0_HI = 22'h3F9FFF;
	localparam logic [21:0] Z7_LO = 22'h3FC000;
	localparam logic [21:0] BROM_LO = 22'h3FF000;
	localparam logic [21:0] TOP_HI = 22'h3FFFFF;
	// ****************************************************************
	// Write-protected ranges.
	// ****************************************************************
	localparam logic [21:0] WP_EMU_LO = 22'h000880;
	localparam logic [21:0] WP_EMU_HI = 22'h0009FF;
	localparam logic [21:0] WP_FLREG_LO = 22'h000A80;
	localparam logic [21:0] WP_FLREG_HI = 22'h000ADF;
	localparam logic [21:0] WP_CSM_LO = 22'h000AE0;
	localparam logic [21:0] WP_CSM_HI = 22'h000AEF;
	localparam logic [21:0] WP_PIEV_LO = 22'h000D00;
	localparam logic [21:0] WP_PIEV_HI = 22'h000DFF;
	localparam logic [21:0] WP_SYS_LO = 22'h007010;
	localparam logic [21:0] WP_SYS_HI = 22'h00702F;
	localparam logic [21:0] WP_GPMUX_LO = 22'h0070C0;
	localparam logic [21:0] WP_GPMUX_HI = 22'h0070DF;
	// ****************************************************************
	// Wait states, configuration and reset values.
	// ****************************************************************
	localparam logic [5:0] WAIT_ZERO = 6'h00;
	localparam logic [5:0] WAIT_ONE = 6'h01;
	localparam logic [5:0] WAIT_PF_READ = 6'h02;
	localparam logic [5:0] WAIT_PASSWORD = 6'h10;
	localparam logic [5:0] WAIT_BROM = 6'h01;
	localparam logic [5:0] PROT_ALIGN_CYCLES = 6'h01;
	localparam int MODE_BIT = 8;
	localparam logic [15:0] EXT_CFG_RESET = 16'h0000;
	localparam logic [15:0] EXT_CFG_MASK = 16'h0100;
	localparam logic [2:0] PROT_RESET = 3'h7;
	localparam int PROT_PF1 = 0;
	localparam int PROT_PF2 = 1;
	localparam int PROT_Z1 = 2;
	typedef enum logic [3:0] {
		TGT_NONE = 4'h0, TGT_M01 = 4'h1, TGT_PF0 = 4'h2, TGT_PF1 = 4'h3,
		TGT_PF2 = 4'h4, TGT_L01 = 4'h5, TGT_H0 = 4'h6, TGT_OTP = 4'h7,
		TGT_FLASH = 4'h8, TGT_BROM = 4'h9, TGT_Z0 = 4'hA, TGT_Z1 = 4'hB,
		TGT_Z2 = 4'hC, TGT_Z6 = 4'hD, TGT_Z7 = 4'hE
	} mmd_target_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} mmd_state_t;
endpackage
`default_nettype wire

/* src/mmd_wait_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module mmd_wait_timer (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Load and ready.
	input wire logic load_in,
	input wire logic [5:0] count_in,
	input wire logic use_ready_in,
	input wire logic ready_in,
	// Status.
	output logic expired_out
);
	logic [5:0] cnt_reg;
	logic use_ready_reg;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= 6'h00;
			use_ready_reg <= 1'b0;
		end else if (load_in) begin
			cnt_reg <= count_in;
			use_ready_reg <= use_ready_in;
		end else if (cnt_reg != 6'h00) begin
			cnt_reg <= cnt_reg - 6'h01;
		end
	end

	// The external ready input only stretches once the programmed count has run out.
	assign expired_out = (cnt_reg == 6'h00) && (!use_ready_reg || ready_in);
endmodule
`default_nettype wire

/* src/mmd_cfg_state.sv */
`timescale 1ns/1ps
`default_nettype none
module mmd_cfg_state (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Strap and software writes.
	input wire logic boot_source_select_pin_in,
	input wire logic ext_cfg_wr_in,
	input wire logic [15:0] ext_cfg_data_in,
	input wire logic prot_wr_in,
	input wire logic [2:0] prot_data_in,
	input wire logic protected_write_unlock_in,
	input wire logic protected_write_lock_in,
	// State.
	output logic [15:0] external_bus_config_reg_out,
	output logic [2:0] prot_cfg_out,
	output logic unlocked_out
);
	logic strap_taken_reg;

	// The strap is caught at the first edge after reset release.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			strap_taken_reg <= 1'b0;
			external_bus_config_reg_out <= mmd_pkg::EXT_CFG_RESET;
		end else if (!strap_taken_reg) begin
			strap_taken_reg <= 1'b1;
			external_bus_config_reg_out[mmd_pkg::MODE_BIT] <= boot_source_select_pin_in;
		end else if (ext_cfg_wr_in) begin
			external_bus_config_reg_out <= ext_cfg_data_in & mmd_pkg::EXT_CFG_MASK;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prot_cfg_out <= mmd_pkg::PROT_RESET;
		end else if (prot_wr_in) begin
			prot_cfg_out <= prot_data_in;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			unlocked_out <= 1'b0;
		end else if (protected_write_lock_in) begin
			unlocked_out <= 1'b0;
		end else if (protected_write_unlock_in) begin
			unlocked_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* src/mmd_decoder.sv */
// Summary of operation
// - Program-space accesses to the three peripheral frames are refused.
// - A protected read of another address right after a protected write gets one alignment cycle, kept in order.
// - Ordered protection starts on for frames 1, 2 and zone 1; software may change it.
// - Five external zones, each with its own wait count and ready-use choice.
// - Zones 0/1 share one select, zones 6/7 another.
// - Boot-source pin is sampled at reset; high selects external zone 7.
// - Microprocessor mode maps zone 7 high and disables the boot ROM.
// - Microcomputer mode disables zone 7; vectors come from boot ROM.
// - Reset pin level lands in the mode bit; software writes remap.
// - Mode changes leave all other blocks mapped as before.
// - No I/O space on the external bus; only memory space decodes.
// - Frames 1 and 2: writes zero wait, reads two wait.
// - OTP uses programmed wait count, minimum one.
// - Flash uses programmed wait, may be zero; password words always sixteen.
// - External zones take at least one wait; ready may stretch further.
// - Frame 0 accepts 16-bit and 32-bit accesses.
// - CAN control registers need 32-bit even-aligned writes.
// - Frame 2 accepts only 16-bit writes; 32-bit writes are ignored.
// - Protected-range writes blocked until unlock, blocked again after lock.
// - Flash control registers also need the security module unlocked.
// - Top eight flash words decode as the 128-bit password.
// - Two flash words below the password decode as boot entry point.
// - Boot-source mode is bit 8 of the external bus config register.
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder #(
	parameter int ZONES = 5,
	parameter int ZW = 5
) (
	// Clock and reset.
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	// Core request.
	input wire logic req_valid_in,
	input wire logic [21:0] req_addr_in,
	input wire logic req_write_in,
	input wire logic req_prog_in,
	input wire logic req_io_in,
	input wire logic req_wide_in,
	// Configuration.
	input wire logic boot_source_select_pin_in,
	input wire logic ext_cfg_wr_in,
	input wire logic [15:0] ext_cfg_data_in,
	input wire logic prot_wr_in,
	input wire logic [2:0] prot_data_in,
	input wire logic protected_write_unlock_in,
	input wire logic protected_write_lock_in,
	input wire logic code_security_locked_in,
	input wire logic [ZONES*ZW-1:0] zone_wait_in,
	input wire logic [ZONES-1:0] zone_ready_use_in,
	input wire logic [3:0] flash_wait_in,
	input wire logic [3:0] otp_wait_in,
	// External bus.
	input wire logic ext_ready_in,
	output logic zone_pair_low_select_n_out,
	output logic zone2_select_n_out,
	output logic zone_pair_high_select_n_out,
	// Access result.
	output logic req_ready_out,
	output logic [3:0] target_out,
	output logic fault_out,
	output logic write_allowed_out,
	output logic password_hit_out,
	output logic entry_point_hit_out,
	output logic done_out,
	output logic write_strobe_out,
	output logic [15:0] external_bus_config_out
);
	// ****************************************************************
	// Configuration state and wait timer.
	// ****************************************************************
	logic [2:0] prot_cfg;
	logic unlocked;
	logic mode_bit;
	logic expired;
	logic accept;
	mmd_pkg::mmd_state_t state_reg;

	mmd_cfg_state u_cfg (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.boot_source_select_pin_in(boot_source_select_pin_in),
		.ext_cfg_wr_in(ext_cfg_wr_in),
		.ext_cfg_data_in(ext_cfg_data_in),
		.prot_wr_in(prot_wr_in),
		.prot_data_in(prot_data_in),
		.protected_write_unlock_in(protected_write_unlock_in),
		.protected_write_lock_in(protected_write_lock_in),
		.external_bus_config_reg_out(external_bus_config_out),
		.prot_cfg_out(prot_cfg),
		.unlocked_out(unlocked)
	);
	assign mode_bit = external_bus_config_out[mmd_pkg::MODE_BIT];
	assign accept = req_valid_in && (state_reg == mmd_pkg::ST_IDLE);

	// ****************************************************************
	// Address decode.
	// ****************************************************************
	mmd_pkg::mmd_target_t dec_tgt;
	logic dec_fault;
	logic dec_wr_ok;
	logic dec_prot;
	logic dec_use_rdy;
	logic [5:0] dec_wait;
	logic [5:0] zwait;
	logic [2:0] zidx;
	logic wprot;
	logic in_pf;
	logic last_prot_wr_reg;
	logic [21:0] last_addr_reg;
	logic [21:0] a;

	always_comb begin
		a = req_addr_in;
		dec_tgt = mmd_pkg::TGT_NONE;
		zidx = 3'h0;
		if (a <= mmd_pkg::M01_HI) dec_tgt = mmd_pkg::TGT_M01;
		else if (a >= mmd_pkg::PF0_LO && a <= mmd_pkg::PF0_HI) dec_tgt = mmd_pkg::TGT_PF0;
		else if (a >= mmd_pkg::Z0_LO && a <= mmd_pkg::Z0_HI) dec_tgt = mmd_pkg::TGT_Z0;
		else if (a >= mmd_pkg::Z1_LO && a <= mmd_pkg::Z1_HI) dec_tgt = mmd_pkg::TGT_Z1;
		else if (a >= mmd_pkg::PF1_LO && a <= mmd_pkg::PF1_HI) dec_tgt = mmd_pkg::TGT_PF1;
		else if (a >= mmd_pkg::PF2_LO && a <= mmd_pkg::PF2_HI) dec_tgt = mmd_pkg::TGT_PF2;
		else if (a >= mmd_pkg::L01_LO && a <= mmd_pkg::L01_HI) dec_tgt = mmd_pkg::TGT_L01;
		else if (a >= mmd_pkg::Z2_LO && a <= mmd_pkg::Z2_HI) dec_tgt = mmd_pkg::TGT_Z2;
		else if (a >= mmd_pkg::Z6_LO && a <= mmd_pkg::Z6_HI) dec_tgt = mmd_pkg::TGT_Z6;
		else if (a >= mmd_pkg::OTP_LO && a <= mmd_pkg::OTP_HI) dec_tgt = mmd_pkg::TGT_OTP;
		else if (a >= mmd_pkg::FLASH_LO && a <= mmd_pkg::FLASH_HI) dec_tgt = mmd_pkg::TGT_FLASH;
		else if (a >= mmd_pkg::H0_LO && a <= mmd_pkg::H0_HI) dec_tgt = mmd_pkg::TGT_H0;
		else if (a >= mmd_pkg::Z7_LO && mode_bit) dec_tgt = mmd_pkg::TGT_Z7;
		else if (a >= mmd_pkg::BROM_LO && !mode_bit) dec_tgt = mmd_pkg::TGT_BROM;
		case (dec_tgt)
			mmd_pkg::TGT_Z1: zidx = 3'h1;
			mmd_pkg::TGT_Z2: zidx = 3'h2;
			mmd_pkg::TGT_Z6: zidx = 3'h3;
			mmd_pkg::TGT_Z7: zidx = 3'h4;
			default: zidx = 3'h0;
		endcase
		// Every external zone has its own count and ready choice.
		zwait = {1'b0, zone_wait_in[zidx*ZW +: ZW]};
		dec_use_rdy = 1'b0;
		in_pf = (dec_tgt == mmd_pkg::TGT_PF0) || (dec_tgt == mmd_pkg::TGT_PF1) ||
			(dec_tgt == mmd_pkg::TGT_PF2);
		dec_fault = (dec_tgt == mmd_pkg::TGT_NONE) || req_io_in;
		if (req_prog_in && in_pf) begin
			dec_fault = 1'b1;
		end
		wprot = (a >= mmd_pkg::WP_EMU_LO && a <= mmd_pkg::WP_EMU_HI) ||
			(a >= mmd_pkg::WP_FLREG_LO && a <= mmd_pkg::WP_FLREG_HI) ||
			(a >= mmd_pkg::WP_CSM_LO && a <= mmd_pkg::WP_CSM_HI) ||
			(a >= mmd_pkg::WP_PIEV_LO && a <= mmd_pkg::WP_PIEV_HI) ||
			(a >= mmd_pkg::WP_SYS_LO && a <= mmd_pkg::WP_SYS_HI) ||
			(a >= mmd_pkg::WP_GPMUX_LO && a <= mmd_pkg::WP_GPMUX_HI);
		dec_wr_ok = req_write_in && !dec_fault && (!wprot || unlocked);
		if (a >= mmd_pkg::WP_FLREG_LO && a <= mmd_pkg::WP_FLREG_HI && code_security_locked_in) begin
			dec_wr_ok = 1'b0;
		end
		// Frame 0 takes either width, so no width check applies there.
		if (dec_tgt == mmd_pkg::TGT_PF2 && req_wide_in) begin
			dec_wr_ok = 1'b0;
		end
		if (dec_tgt == mmd_pkg::TGT_PF1 && a <= mmd_pkg::CAN_CTL_HI && (!req_wide_in || a[0])) begin
			dec_wr_ok = 1'b0;
		end
		case (dec_tgt)
			mmd_pkg::TGT_PF1, mmd_pkg::TGT_PF2: begin
				dec_wait = req_write_in ? mmd_pkg::WAIT_ZERO : mmd_pkg::WAIT_PF_READ;
			end
			mmd_pkg::TGT_OTP: begin
				dec_wait = (otp_wait_in == 4'h0) ? mmd_pkg::WAIT_ONE : {2'b00, otp_wait_in};
			end
			mmd_pkg::TGT_FLASH: begin
				dec_wait = {2'b00, flash_wait_in};
				if (a >= mmd_pkg::PWD_LO) begin
					dec_wait = mmd_pkg::WAIT_PASSWORD;
				end
			end
			mmd_pkg::TGT_BROM: dec_wait = mmd_pkg::WAIT_BROM;
			mmd_pkg::TGT_Z0, mmd_pkg::TGT_Z1, mmd_pkg::TGT_Z2, mmd_pkg::TGT_Z6,
			mmd_pkg::TGT_Z7: begin
				dec_wait = (zwait == 6'h00) ? mmd_pkg::WAIT_ONE : zwait;
				dec_use_rdy = zone_ready_use_in[zidx];
			end
			default: dec_wait = mmd_pkg::WAIT_ZERO;
		endcase
		if (dec_fault) begin
			dec_wait = mmd_pkg::WAIT_ZERO;
			dec_use_rdy = 1'b0;
		end
		dec_prot = !dec_fault && ((dec_tgt == mmd_pkg::TGT_PF1 && prot_cfg[mmd_pkg::PROT_PF1]) ||
			(dec_tgt == mmd_pkg::TGT_PF2 && prot_cfg[mmd_pkg::PROT_PF2]) ||
			(dec_tgt == mmd_pkg::TGT_Z1 && prot_cfg[mmd_pkg::PROT_Z1]));
		// A protected read of another address right after a protected write waits so the write stays first.
		if (dec_prot && !req_write_in && last_prot_wr_reg && a != last_addr_reg) begin
			dec_wait = dec_wait + mmd_pkg::PROT_ALIGN_CYCLES;
		end
	end

	mmd_wait_timer u_wait (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.load_in(accept),
		.count_in(dec_wait),
		.use_ready_in(dec_use_rdy),
		.ready_in(ext_ready_in),
		.expired_out(expired)
	);

	// ****************************************************************
	// Access sequencing.
	// ****************************************************************
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= mmd_pkg::ST_IDLE;
			req_ready_out <= 1'b0;
			done_out <= 1'b0;
			write_strobe_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			write_strobe_out <= 1'b0;
			case (state_reg)
				mmd_pkg::ST_IDLE: begin
					req_ready_out <= 1'b1;
					if (accept) begin
						state_reg <= mmd_pkg::ST_WAIT;
						req_ready_out <= 1'b0;
					end
				end
				mmd_pkg::ST_WAIT: begin
					if (expired) begin
						state_reg <= mmd_pkg::ST_IDLE;
						req_ready_out <= 1'b1;
						done_out <= 1'b1;
						write_strobe_out <= write_allowed_out;
					end
				end
				default: state_reg <= mmd_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			target_out <= 4'h0;
			fault_out <= 1'b0;
			write_allowed_out <= 1'b0;
			password_hit_out <= 1'b0;
			entry_point_hit_out <= 1'b0;
			last_prot_wr_reg <= 1'b0;
			last_addr_reg <= 22'h000000;
		end else if (accept) begin
			target_out <= dec_fault ? 4'h0 : dec_tgt;
			fault_out <= dec_fault;
			write_allowed_out <= dec_wr_ok;
			password_hit_out <= !dec_fault && a >= mmd_pkg::PWD_LO && a <= mmd_pkg::PWD_HI;
			entry_point_hit_out <= !dec_fault && a >= mmd_pkg::ENTRY_LO &&
				a <= mmd_pkg::ENTRY_HI;
			last_prot_wr_reg <= dec_prot && req_write_in;
			last_addr_reg <= a;
		end
	end

	// Paired zones drive one shared select, giving mirrored images.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			zone_pair_low_select_n_out <= 1'b1;
			zone2_select_n_out <= 1'b1;
			zone_pair_high_select_n_out <= 1'b1;
		end else if (accept && !dec_fault) begin
			zone_pair_low_select_n_out <= !(dec_tgt == mmd_pkg::TGT_Z0 ||
				dec_tgt == mmd_pkg::TGT_Z1);
			zone2_select_n_out <= !(dec_tgt == mmd_pkg::TGT_Z2);
			zone_pair_high_select_n_out <= !(dec_tgt == mmd_pkg::TGT_Z6 ||
				dec_tgt == mmd_pkg::TGT_Z7);
		end else if (state_reg == mmd_pkg::ST_WAIT && expired) begin
			zone_pair_low_select_n_out <= 1'b1;
			zone2_select_n_out <= 1'b1;
			zone_pair_high_select_n_out <= 1'b1;
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	prog_frame_block_a: assert property (accept && req_prog_in && (a >= mmd_pkg::PF0_LO) && (a <= mmd_pkg::PF2_HI) && !(a >= mmd_pkg::Z0_LO && a <= mmd_pkg::Z1_HI) |=> fault_out && target_out == 4'h0) else $error("program access reached a frame");
	pf_read_wait_a: assert property (accept && !req_write_in && !dec_fault && (dec_tgt == mmd_pkg::TGT_PF1 || dec_tgt == mmd_pkg::TGT_PF2) && !(last_prot_wr_reg && a != last_addr_reg) |=> !done_out [*3] ##1 done_out) else $error("frame read wait not two");
	pf_write_wait_a: assert property (accept && req_write_in && (dec_tgt == mmd_pkg::TGT_PF1 || dec_tgt == mmd_pkg::TGT_PF2) && !dec_fault |=> !done_out ##1 done_out) else $error("frame write wait not zero");
	password_wait_a: assert property (accept && !dec_fault && dec_tgt == mmd_pkg::TGT_FLASH && a >= mmd_pkg::PWD_LO |-> ##18 done_out) else $error("password wait not sixteen");
	ext_min_wait_a: assert property (accept && !dec_fault && dec_tgt >= mmd_pkg::TGT_Z0 |=> !done_out [*2]) else $error("external access without wait");
	pair_select_a: assert property (!zone_pair_low_select_n_out |-> (target_out == mmd_pkg::TGT_Z0 || target_out == mmd_pkg::TGT_Z1)) else $error("low pair select misused");
	frame2_wide_a: assert property (accept && req_wide_in && dec_tgt == mmd_pkg::TGT_PF2 |=> !write_allowed_out) else $error("wide frame 2 write passed");
	write_lock_a: assert property (accept && req_write_in && a >= mmd_pkg::WP_GPMUX_LO && a <= mmd_pkg::WP_GPMUX_HI && !unlocked |=> !write_allowed_out) else $error("locked write passed");
	zone7_mode_a: assert property (accept && !req_io_in && a >= mmd_pkg::Z7_LO |=>
		(target_out == mmd_pkg::TGT_Z7) == $past(mode_bit)) else $error("zone 7 mapping wrong for mode");
	io_refused_a: assert property (accept && req_io_in |=> fault_out && !write_allowed_out) else $error("io space access decoded");

	pf2_read_c: cover property (accept && !req_write_in && dec_tgt == mmd_pkg::TGT_PF2 ##4 done_out);
	ext_stall_c: cover property (state_reg == mmd_pkg::ST_WAIT && !ext_ready_in && !zone2_select_n_out ##1 done_out);
	password_c: cover property (accept && password_hit_out == 1'b0 ##1 password_hit_out);
endmodule
`default_nettype wire

/* tb/mmd_ext_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mmd_ext_model (
	// Clock, reset and selects.
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [2:0] sel_n_in,
	input wire logic [3:0] stall_in,
	// Ready back to the decoder.
	output logic ready_out
);
	logic [3:0] cnt_reg;
	// Ready toggles while unselected, so a stale level is never trusted.
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= 4'h0;
			ready_out <= 1'b0;
		end else if (&sel_n_in) begin
			cnt_reg <= 4'h0;
			ready_out <= ~ready_out;
		end else begin
			cnt_reg <= cnt_reg + 4'h1;
			ready_out <= (cnt_reg >= stall_in);
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic ref_clk_in = 1'b0, rst_n_in = 1'b0, req_valid_in = 1'b0, req_write_in = 1'b0;
	logic req_prog_in = 1'b0, req_io_in = 1'b0, req_wide_in = 1'b0, ext_cfg_wr_in = 1'b0;
	logic boot_source_select_pin_in = 1'b1, prot_wr_in = 1'b0, protected_write_unlock_in = 1'b0;
	logic protected_write_lock_in = 1'b0, code_security_locked_in = 1'b1, ext_ready_in;
	logic [21:0] req_addr_in = 22'h000000;
	logic [15:0] ext_cfg_data_in = 16'h0000;
	logic [2:0] prot_data_in = 3'h7;
	logic [24:0] zone_wait_in = {5'h01, 5'h02, 5'h00, 5'h01, 5'h01};
	logic [4:0] zone_ready_use_in = 5'h02;
	logic [3:0] flash_wait_in = 4'h0, otp_wait_in = 4'h0, target_out;
	logic zone_pair_low_select_n_out, zone2_select_n_out, zone_pair_high_select_n_out;
	logic req_ready_out, fault_out, write_allowed_out, password_hit_out, entry_point_hit_out;
	logic done_out, write_strobe_out;
	logic [15:0] external_bus_config_out;
	logic [2:0] last_sel;
	int num_errors = 0, checked = 0, last_k = 0;
	always #20 ref_clk_in = ~ref_clk_in;
	mmd_decoder u_mmd_decoder (.ref_clk_in, .rst_n_in, .req_valid_in, .req_addr_in,
		.req_write_in, .req_prog_in, .req_io_in, .req_wide_in, .boot_source_select_pin_in,
		.ext_cfg_wr_in, .ext_cfg_data_in, .prot_wr_in, .prot_data_in, .protected_write_unlock_in,
		.protected_write_lock_in, .code_security_locked_in, .zone_wait_in, .zone_ready_use_in,
		.flash_wait_in, .otp_wait_in, .ext_ready_in, .zone_pair_low_select_n_out,
		.zone2_select_n_out, .zone_pair_high_select_n_out, .req_ready_out, .target_out,
		.fault_out, .write_allowed_out, .password_hit_out, .entry_point_hit_out, .done_out,
		.write_strobe_out, .external_bus_config_out);
	mmd_ext_model u_mmd_ext_model (.ref_clk_in, .rst_n_in, .stall_in(4'h3), .ready_out(ext_ready_in),
		.sel_n_in({zone_pair_high_select_n_out, zone2_select_n_out, zone_pair_low_select_n_out}));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Kind is {program, io, wide}; flags are {fault, write allowed, password, entry}.
	task automatic acc(input logic [21:0] a, input logic w, input logic [2:0] kind, input int ek,
		input logic [3:0] et, input logic [3:0] ef);
		int k;
		k = 0;
		last_sel = 3'h7;
		@(negedge ref_clk_in);
		while (req_ready_out !== 1'b1 && k < 50) begin
			@(negedge ref_clk_in);
			k++;
		end
		chk(req_ready_out, 1'b1);
		@(posedge ref_clk_in);
		req_valid_in <= 1'b1;
		req_addr_in <= a;
		req_write_in <= w;
		{req_prog_in, req_io_in, req_wide_in} <= kind;
		@(posedge ref_clk_in);
		req_valid_in <= 1'b0;
		k = 0;
		do begin
			@(negedge ref_clk_in);
			k++;
			last_sel &= {zone_pair_high_select_n_out, zone2_select_n_out, zone_pair_low_select_n_out};
		end while (done_out !== 1'b1 && k < 100);
		chk(done_out, 1'b1);
		last_k = k;
		if (ek != 0) chk(k, ek);
		if (et != 4'hF) chk(target_out, et);
		chk({fault_out, w & write_allowed_out, password_hit_out, entry_point_hit_out}, ef);
		chk(write_strobe_out, w & ef[2]);
	endtask
	task automatic pulse(input int which);
		@(posedge ref_clk_in);
		{ext_cfg_wr_in, protected_write_unlock_in, protected_write_lock_in,
			prot_wr_in} <= 4'h8 >> which;
		@(posedge ref_clk_in);
		{ext_cfg_wr_in, protected_write_unlock_in, protected_write_lock_in,
			prot_wr_in} <= 4'h0;
	endtask
	task automatic t_boot;
		chk(external_bus_config_out, 16'h0100);
		acc(22'h3FF000, 0, 3'h0, 3, mmd_pkg::TGT_Z7, 4'h0);
		chk(last_sel, 3'h3);
		pulse(0);
		acc(22'h3FF000, 0, 3'h0, 3, mmd_pkg::TGT_BROM, 4'h0);
		acc(22'h3FC000, 0, 3'h0, 2, mmd_pkg::TGT_NONE, 4'h8);
		acc(mmd_pkg::H0_LO, 0, 3'h0, 2, mmd_pkg::TGT_H0, 4'h0);
		chk(external_bus_config_out, 16'h0000);
		$display("boot test done");
	endtask
	task automatic t_space;
		acc(22'h006100, 0, 3'h4, 2, 4'hF, 4'h8);
		acc(22'h007040, 0, 3'h4, 2, 4'hF, 4'h8);
		acc(22'h000C00, 0, 3'h4, 2, 4'hF, 4'h8);
		acc(mmd_pkg::Z2_LO, 0, 3'h2, 2, 4'hF, 4'h8);
		acc(22'h001000, 1, 3'h0, 2, 4'hF, 4'h8);
		$display("space test done");
	endtask
	task automatic t_zone;
		acc(mmd_pkg::Z0_LO, 0, 3'h0, 3, mmd_pkg::TGT_Z0, 4'h0);
		chk(last_sel, 3'h6);
		acc(mmd_pkg::Z2_LO, 0, 3'h0, 3, mmd_pkg::TGT_Z2, 4'h0);
		chk(last_sel, 3'h5);
		acc(mmd_pkg::Z6_LO, 0, 3'h0, 4, mmd_pkg::TGT_Z6, 4'h0);
		chk(last_sel, 3'h3);
		acc(mmd_pkg::Z1_LO, 0, 3'h0, 0, mmd_pkg::TGT_Z1, 4'h0);
		chk({last_sel, 1'(last_k >= 4)}, 4'hD);
		$display("zone test done");
	endtask
	task automatic t_mem;
		acc(mmd_pkg::FLASH_LO, 0, 3'h0, 2, mmd_pkg::TGT_FLASH, 4'h0);
		acc(mmd_pkg::PWD_LO, 0, 3'h0, 18, 4'hF, 4'h2);
		acc(mmd_pkg::PWD_HI, 0, 3'h0, 18, 4'hF, 4'h2);
		acc(mmd_pkg::ENTRY_LO, 0, 3'h0, 2, 4'hF, 4'h1);
		acc(mmd_pkg::OTP_LO, 0, 3'h0, 3, mmd_pkg::TGT_OTP, 4'h0);
		$display("memory test done");
	endtask
	task automatic t_frames;
		acc(22'h007040, 0, 3'h0, 4, mmd_pkg::TGT_PF2, 4'h0);
		acc(22'h007040, 1, 3'h0, 2, mmd_pkg::TGT_PF2, 4'h4);
		acc(22'h007040, 1, 3'h1, 2, mmd_pkg::TGT_PF2, 4'h0);
		acc(22'h000C00, 1, 3'h1, 2, mmd_pkg::TGT_PF0, 4'h4);
		acc(22'h006000, 1, 3'h0, 2, mmd_pkg::TGT_PF1, 4'h0);
		acc(22'h006000, 1, 3'h1, 2, mmd_pkg::TGT_PF1, 4'h4);
		acc(22'h006001, 1, 3'h1, 2, mmd_pkg::TGT_PF1, 4'h0);
		acc(22'h007040, 0, 3'h0, 5, mmd_pkg::TGT_PF2, 4'h0);
		@(posedge ref_clk_in) prot_data_in <= 3'h0;
		pulse(3);
		acc(22'h006000, 1, 3'h1, 2, mmd_pkg::TGT_PF1, 4'h4);
		acc(22'h007040, 0, 3'h0, 4, mmd_pkg::TGT_PF2, 4'h0);
		$display("frame test done");
	endtask
	task automatic t_wp;
		acc(22'h007010, 1, 3'h0, 2, mmd_pkg::TGT_PF2, 4'h0);
		pulse(1);
		acc(22'h007010, 1, 3'h0, 2, mmd_pkg::TGT_PF2, 4'h4);
		acc(mmd_pkg::WP_FLREG_LO, 1, 3'h0, 2, mmd_pkg::TGT_PF0, 4'h0);
		@(posedge ref_clk_in) code_security_locked_in <= 1'b0;
		acc(mmd_pkg::WP_FLREG_LO, 1, 3'h0, 2, mmd_pkg::TGT_PF0, 4'h4);
		pulse(2);
		acc(22'h007010, 1, 3'h0, 2, mmd_pkg::TGT_PF2, 4'h0);
		$display("write protect test done");
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		t_boot();
		t_space();
		t_zone();
		t_mem();
		t_frames();
		t_wp();
		summarize();
	end
	initial begin
		#200000;
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
